//--- src/gfc_pkg.sv
/*
 * Constants for the gated frequency counter: gate timing, result codes,
 * counter width and the control state encoding.
 * Assumes a single 100 MHz system clock.
 */
package gfc_pkg;
    localparam int          CLK_FREQ_HZ    = 100_000_000;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          GATE_TIME_MS   = 100;
    // 100 ms at 10 ns: 10,000,000 cycles
    localparam int          GATE_CYCLES    = GATE_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int          GATE_CNT_W     = 24;
    localparam int          MAX_EDGE_HZ    = 2_500_000;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] RESULT_PENDING = 16'h0000;
    localparam logic [15:0] RESULT_ERROR   = 16'hFFFF;
    localparam logic [15:0] CNT_RESET      = 16'h0000;

    typedef enum logic [3:0] {
        GFC_IDLE  = 4'b0001,
        GFC_ARMED = 4'b0010,
        GFC_GATE  = 4'b0100,
        GFC_DONE  = 4'b1000
    } gfc_state_t;
endpackage : gfc_pkg

//--- src/gfc_gate_timer.sv
/*
 * Reference gate timer: counts a fixed number of clocks after a start pulse
 * and emits a one-cycle expiry pulse.
 * Assumes start is only pulsed while the timer is idle.
 */
`timescale 1ns/1ps
`default_nettype none
module gfc_gate_timer #(
    parameter int GATE_CYCLES = gfc_pkg::GATE_CYCLES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      expire_o
);
    import gfc_pkg::*;

    typedef struct packed {
        logic                  run;
        logic [GATE_CNT_W-1:0] cnt;
        logic                  expire;
    } gfc_tmr_t;

    gfc_tmr_t s_reg;
    gfc_tmr_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.expire = 1'b0;
        if (abort_i) begin
            s_next.run = 1'b0;
        end else if (start_i) begin
            s_next.run = 1'b1;
            s_next.cnt = GATE_CNT_W'(GATE_CYCLES - 1);
        end else if (s_reg.run) begin
            if (s_reg.cnt == '0) begin
                s_next.run    = 1'b0;
                s_next.expire = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign expire_o = s_reg.expire;
endmodule : gfc_gate_timer
`default_nettype wire

//--- src/gfc_top.sv
/*
 * Gated frequency counter: counts rising edges of an external input during
 * a 100 ms gate and presents pending, count or error code as the result.
 * Assumes START/CLEAR are one-cycle pulses synchronous to REF_CLK_I.
 */
//Contract
//- A start arms the block and counting begins on the first level change of the counting input.
//- While a started measurement is incomplete the result reads zero.
//- A good measurement presents its count, always below the all-ones code.
//- An error such as counter overflow presents the all-ones code.
//- The user clears after reading, and the clear discards the held result.
//- The count accumulates for the 100 ms gate plus one clock (GATE_CYCLES + 1 clocks), giving one tenth of the frequency.
//- Input edges up to half the clock rate are counted; the ceiling scales with the clock.
//- Gate expiry stops the edge counter at once and freezes the result.
//- The edge counter is 16 bits wide.
`timescale 1ns/1ps
`default_nettype none
module gfc_top #(
    parameter int GATE_CYCLES = gfc_pkg::GATE_CYCLES
) (
    // Clock and reset
    input  wire logic              REF_CLK_I,
    input  wire logic              RST_I,
    // Measured signal
    input  wire logic              EXT_COUNT_INPUT_I,
    // Requests
    input  wire logic              START_I,
    input  wire logic              CLEAR_I,
    // Result
    output logic [gfc_pkg::CNT_W-1:0] RESULT_O,
    output logic                   BUSY_O,
    output logic                   DONE_O
);
    import gfc_pkg::*;

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             prev;
        gfc_state_t       state;
        logic [CNT_W-1:0] cnt;
        logic             ovf;
        logic [CNT_W-1:0] result;
        logic             busy;
        logic             done;
    } gfc_top_t;

    gfc_top_t s_reg;
    gfc_top_t s_next;
    logic     gate_start;
    logic     gate_expire;
    logic     rise;
    logic     change;

    // Clear aborts a running gate so a stale expiry cannot land later
    gfc_gate_timer #(
        .GATE_CYCLES (GATE_CYCLES)
    ) u_gate (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .start_i  (gate_start),
        .abort_i  (CLEAR_I),
        .expire_o (gate_expire)
    );

    // Only the second stage and its delayed copy are inspected, never the first
    assign rise   = s_reg.sync2 & ~s_reg.prev;
    assign change = s_reg.sync2 ^ s_reg.prev;
    assign gate_start = (s_reg.state == GFC_ARMED) && change && !CLEAR_I;

    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = EXT_COUNT_INPUT_I;
        s_next.sync2 = s_reg.sync1;
        s_next.prev  = s_reg.sync2;
        case (s_reg.state)
            GFC_IDLE: begin
                if (START_I && !CLEAR_I) begin
                    s_next.state  = GFC_ARMED;
                    s_next.cnt    = CNT_RESET;
                    s_next.ovf    = 1'b0;
                    s_next.result = RESULT_PENDING;
                    s_next.busy   = 1'b1;
                    s_next.done   = 1'b0;
                end
            end
            GFC_ARMED: begin
                if (gate_start) begin
                    s_next.state = GFC_GATE;
                end
            end
            GFC_GATE: begin
                // Edge counting at full clock rate: one edge per 2 clocks max
                if (rise) begin
                    if (s_reg.cnt == RESULT_ERROR - 16'h0001) begin
                        s_next.ovf = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt + 16'h0001;
                    end
                end
                if (gate_expire) begin
                    s_next.state  = GFC_DONE;
                    s_next.busy   = 1'b0;
                    s_next.done   = 1'b1;
                    s_next.result = (s_reg.ovf || (rise && s_reg.cnt == RESULT_ERROR - 16'h0001))
                                    ? RESULT_ERROR : (rise ? s_reg.cnt + 16'h0001 : s_reg.cnt);
                end
            end
            GFC_DONE: begin
            end
            default: begin
                s_next.state = GFC_IDLE;
            end
        endcase
        if (CLEAR_I) begin
            s_next.state  = GFC_IDLE;
            s_next.result = RESULT_PENDING;
            s_next.busy   = 1'b0;
            s_next.done   = 1'b0;
            s_next.cnt    = CNT_RESET;
            s_next.ovf    = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            s_reg       <= '0;
            s_reg.state <= GFC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RESULT_O = s_reg.result;
    assign BUSY_O   = s_reg.busy;
    assign DONE_O   = s_reg.done;

    sequence armed_then_change;
        s_reg.state == GFC_ARMED && change && !CLEAR_I;
    endsequence

    chk_arm_on_change: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        armed_then_change |=> s_reg.state == GFC_GATE)
        else $error("gate did not open on input change");
    chk_armed_waits: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (s_reg.state == GFC_ARMED && !change && !CLEAR_I) |=> s_reg.state == GFC_ARMED)
        else $error("left armed without input change");
    chk_pending_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        BUSY_O |-> RESULT_O == RESULT_PENDING)
        else $error("result not zero while pending");
    chk_good_below: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (DONE_O && !s_reg.ovf) |-> RESULT_O < RESULT_ERROR)
        else $error("good result reached all-ones");
    chk_ovf_error: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (DONE_O && s_reg.ovf) |-> RESULT_O == RESULT_ERROR)
        else $error("overflow not reported as all-ones");
    chk_clear_drops: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CLEAR_I |=> (RESULT_O == RESULT_PENDING && !DONE_O && !BUSY_O))
        else $error("clear did not discard result");
    chk_expire_stops: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (gate_expire && s_reg.state == GFC_GATE && !CLEAR_I) |=> DONE_O && !BUSY_O)
        else $error("expiry did not stop counting");
    chk_frozen_count: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (DONE_O && !CLEAR_I) |=> $stable(RESULT_O))
        else $error("result changed after gate");
    chk_count_step: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (s_reg.state == GFC_GATE && rise && !s_reg.ovf && !gate_expire && !CLEAR_I
         && s_reg.cnt != RESULT_ERROR - 16'h0001) |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001)
        else $error("rising edge not counted once");
    chk_gate_length: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (gate_start ##1 (s_reg.state == GFC_GATE && !CLEAR_I)[*2]) |-> !gate_expire)
        else $error("gate expired too early");
endmodule : gfc_top
`default_nettype wire

//--- tb/gfc_src.sv
/* Periodic signal source for the counting input.
   Assumes the bench clock; levels change only on its rising edge. */
`timescale 1ns/1ps
`default_nettype none
module gfc_src (
    // Control
    input  wire logic       clk_i,
    input  wire logic       en_i,
    input  wire logic [7:0] half_i,
    // Signal
    output logic            sig_o
);
    logic [7:0] cnt_reg;
    initial begin
        sig_o   = 1'b0;
        cnt_reg = 8'h00;
    end
    // Each level held >= 1 clock so no pulse slips the synchroniser
    always @(posedge clk_i) begin
        if (en_i && (cnt_reg + 8'h01 >= half_i)) begin
            sig_o   <= ~sig_o;
            cnt_reg <= 8'h00;
        end else if (en_i) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : gfc_src
`default_nettype wire

//--- tb/gfc_top_bench.sv
/* Self-checking bench for the gated frequency counter.
   Assumes a short gate parameter; overflow needs over 131k cycles, beyond the run budget. */
`timescale 1ns/1ps
`default_nettype none
module gfc_top_bench;
    import gfc_pkg::*;
    localparam int GATE = 50;
    logic             ref_clk;
    logic             rst;
    logic             start;
    logic             clear;
    logic             src_en;
    logic [7:0]       src_half;
    logic             sig;
    logic [CNT_W-1:0] result;
    logic             busy;
    logic             done;
    int               errors = 0;
    int               tests_run = 0;
    int               cycles = 0;
    int               n;

    gfc_top #(.GATE_CYCLES(GATE)) gfc_top_i (
        .REF_CLK_I(ref_clk), .RST_I(rst), .EXT_COUNT_INPUT_I(sig), .START_I(start),
        .CLEAR_I(clear), .RESULT_O(result), .BUSY_O(busy), .DONE_O(done));
    gfc_src gfc_src_i (.clk_i(ref_clk), .en_i(src_en), .half_i(src_half), .sig_o(sig));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic req(input logic s, input logic c);
        @(posedge ref_clk);
        start <= s;
        clear <= c;
        @(posedge ref_clk);
        start <= 1'b0;
        clear <= 1'b0;
        #1;
    endtask : req

    // Count lands within one edge of gate length over period
    task automatic finish_gate(input int h, output int w);
        logic [15:0] r;
        w = 0;
        while (done !== 1'b1 && w < 200) begin
            @(posedge ref_clk);
            #1;
            w++;
        end
        r = result;
        check({15'h0, w < 200}, 16'h0001);
        check({15'h0, r >= (GATE + 1) / (2 * h) - 1 && r <= (GATE + 1) / (2 * h) + 1}, 16'h0001);
        repeat (20) @(posedge ref_clk);
        #1;
        check(result, r);
    endtask : finish_gate

    task automatic t_arm;
        req(1'b1, 1'b0);
        repeat (GATE + 20) @(posedge ref_clk);
        #1;
        check({14'h0, busy, done}, 16'h0002);
        check(result, RESULT_PENDING);
        @(posedge ref_clk);
        src_en <= 1'b1;
        finish_gate(2, n);
    endtask : t_arm

    task automatic t_refuse;
        req(1'b1, 1'b0);
        check({14'h0, busy, done}, 16'h0001);
        req(1'b0, 1'b1);
        check(result, RESULT_PENDING);
        check({14'h0, busy, done}, 16'h0000);
    endtask : t_refuse

    task automatic t_rate;
        @(posedge ref_clk);
        src_half <= 8'h01;
        req(1'b1, 1'b0);
        finish_gate(1, n);
        check({15'h0, n >= GATE + 1 && n <= GATE + 10}, 16'h0001);
        req(1'b0, 1'b1);
    endtask : t_rate

    task automatic t_abort;
        req(1'b1, 1'b0);
        repeat (20) @(posedge ref_clk);
        #1;
        check({14'h0, busy, done}, 16'h0002);
        req(1'b0, 1'b1);
        repeat (GATE + 10) @(posedge ref_clk);
        #1;
        check({14'h0, busy, done}, 16'h0000);
        check(result, RESULT_PENDING);
    endtask : t_abort

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        rst      = 1'b1;
        start    = 1'b0;
        clear    = 1'b0;
        src_en   = 1'b0;
        src_half = 8'h02;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_arm;
        t_refuse;
        t_rate;
        t_abort;
        conclude;
    end

    // Whole sequence needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude;
        end
    end
endmodule : gfc_top_bench
`default_nettype wire
